// ==== rtl/vbic_defines.svh ====
`ifndef VBIC_DEFINES_SVH
`define VBIC_DEFINES_SVH

// ****************************************************************
// Address byte layout
// ****************************************************************
`define VBIC_ADDR_FIXED      5'h0B
`define VBIC_ADDR_SEL_HI_BIT 2
`define VBIC_ADDR_SEL_LO_BIT 1
`define VBIC_ADDR_RW_BIT     0

// ****************************************************************
// Channel subaddresses
// ****************************************************************
`define VBIC_SUB_CH1 8'h01
`define VBIC_SUB_CH2 8'h02
`define VBIC_SUB_CH3 8'h03

// ****************************************************************
// Channel register field positions
// ****************************************************************
`define VBIC_CLAMP_HI_BIT 7
`define VBIC_CLAMP_LO_BIT 6
`define VBIC_BIAS_HI_BIT  2

// ****************************************************************
// Counts and power-up values
// ****************************************************************
`define VBIC_BYTE_BITS    4'h8
`define VBIC_SYNC_STAGES  2
`define VBIC_POWERUP_CFG  24'h5AC381
`define VBIC_READ_INVALID 8'h00

`endif

// ==== rtl/vbic_pkg.sv ====
package vbic_pkg;

  // Clamp loop filter corner as seen by the analog side.
  typedef enum logic [1:0] {
    VBIC_CLAMP_LOW  = 2'b00,
    VBIC_CLAMP_MID  = 2'b01,
    VBIC_CLAMP_HIGH = 2'b10
  } vbic_clamp_t;

  // Video low-pass corner selection, the last code bypasses the filter.
  typedef enum logic [1:0] {
    VBIC_LOWPASS_FIRST  = 2'b00,
    VBIC_LOWPASS_SECOND = 2'b01,
    VBIC_LOWPASS_THIRD  = 2'b10,
    VBIC_LOWPASS_BYPASS = 2'b11
  } vbic_lowpass_t;

  // Channel state and input bias selection.
  typedef enum logic [2:0] {
    VBIC_BIAS_OFF      = 3'b000,
    VBIC_BIAS_MUTE     = 3'b001,
    VBIC_BIAS_DC       = 3'b010,
    VBIC_BIAS_DC_SHIFT = 3'b011,
    VBIC_BIAS_AC       = 3'b100,
    VBIC_BIAS_TIP_LOW  = 3'b101,
    VBIC_BIAS_TIP_MID  = 3'b110,
    VBIC_BIAS_TIP_HIGH = 3'b111
  } vbic_bias_t;

  // One channel configuration byte, most significant field first.
  typedef struct packed {
    logic [1:0]    clamp_filter;
    logic          input_b;
    vbic_lowpass_t video_lowpass_filter;
    vbic_bias_t    bias_mode;
  } vbic_chan_cfg_t;

  // Synchronised pin group.
  typedef struct packed {
    logic scl;
    logic sda;
    logic sel_high;
    logic sel_low;
  } vbic_pins_t;

  // Serial slave sequencer states.
  typedef enum logic [3:0] {
    VBIC_ST_IDLE     = 4'h0,
    VBIC_ST_ADDR     = 4'h1,
    VBIC_ST_ADDR_ACK = 4'h2,
    VBIC_ST_SUB      = 4'h3,
    VBIC_ST_SUB_ACK  = 4'h4,
    VBIC_ST_DATA     = 4'h5,
    VBIC_ST_DATA_ACK = 4'h6,
    VBIC_ST_RD_DATA  = 4'h7,
    VBIC_ST_RD_ACK   = 4'h8,
    VBIC_ST_IGNORE   = 4'h9
  } vbic_state_t;

endpackage

// ==== rtl/vbic_sync.sv ====
// ****************************************************************
// Multi-stage synchroniser for asynchronous pin levels
// ****************************************************************
module vbic_sync #(
  parameter int         WIDTH  = 4,
  parameter int         STAGES = 2,
  parameter logic [3:0] INIT   = 4'hF
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage_q [STAGES];

  if (STAGES < 2) begin : g_bad_stages
    $error("vbic_sync needs at least two stages.");
  end
  if (WIDTH != 4) begin : g_bad_width
    $error("vbic_sync reset value is sized for four lines.");
  end

  // Each stage only feeds the next one, so the first flop is never read by logic.
  for (genvar s = 0; s < STAGES; s++) begin : g_stage
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        stage_q[s] <= INIT;
      end else begin
        stage_q[s] <= (s == 0) ? async_in : stage_q[(s == 0) ? 0 : s - 1];
      end
    end
  end

  assign sync_out = stage_q[STAGES-1];

endmodule

// ==== rtl/vbic_slave.sv ====
`include "vbic_defines.svh"

// Function
// - Channel registers start at arbitrary values until a valid write replaces them.
// - A stuck acknowledge at power-up is dropped after one full serial clock.
// - First byte after start is the address; top five bits must match.
// - Address bits two and one follow the select pins live, never latched.
// - One data byte per transaction; no auto-increment.
// - Subaddress one, two, three selects channel one, two, three.
// - A read returns the channel register of the last subaddress written, or the filler byte if it is out of range.
// - Writing one channel leaves the other two unchanged.
// - Bits seven and six pick the clamp filter, used only in tip clamp.
// - Bit five selects input A or input B.
// - Bits four and three pick the low-pass corner or bypass.
// - Bits two to zero pick off, mute, DC, DC shift, AC or tip clamp.
// - Slave acknowledges address, subaddress and data byte of a write.
// - Address bit zero gives direction: zero write, one read.
// - On a match the slave holds data low through the ninth clock high.
module vbic_slave #(
  parameter logic [23:0] POWERUP_CFG      = `VBIC_POWERUP_CFG,
  parameter bit          STUCK_AT_POWERUP = 1'b1,
  parameter int          SYNC_STAGES      = `VBIC_SYNC_STAGES
) (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  // Two-wire bus pins
  input  wire logic                    scl_pin,
  input  wire logic                    sda_in,
  output logic                         sda_out_q,
  output logic                         sda_oe_n_q,
  // Address select pins
  input  wire logic                    addr_select_high_pin,
  input  wire logic                    addr_select_low_pin,
  // Channel configuration
  output vbic_pkg::vbic_chan_cfg_t     chan_cfg_q [3],
  output logic [2:0]                   sync_tip_clamp_q,
  output vbic_pkg::vbic_clamp_t        clamp_corner_q [3]
);
  import vbic_pkg::*;

  localparam int NUM_CH = 3;

  if (SYNC_STAGES < 2) begin : g_bad_sync
    $error("vbic_slave needs at least two synchroniser stages.");
  end

  // ****************************************************************
  // Pin synchronisation and bus condition detection
  // ****************************************************************
  logic [3:0]  pins_raw;
  logic [3:0]  pins_sync;
  vbic_pins_t  pins_s;
  logic        scl_q;
  logic        sda_q;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_det;
  logic        stop_det;

  assign pins_raw = {scl_pin, sda_in, addr_select_high_pin, addr_select_low_pin};

  vbic_sync #(
    .WIDTH  (4),
    .STAGES (SYNC_STAGES),
    .INIT   (4'hF)
  ) u_sync (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .async_in (pins_raw),
    .sync_out (pins_sync)
  );

  assign pins_s = vbic_pins_t'(pins_sync);

  // Previous synchronised levels for edge detection.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= pins_s.scl;
      sda_q <= pins_s.sda;
    end
  end

  // Data moving while the clock stays high marks start or stop.
  assign scl_rise  = pins_s.scl & ~scl_q;
  assign scl_fall  = ~pins_s.scl & scl_q;
  assign start_det = pins_s.scl & scl_q & sda_q & ~pins_s.sda;
  assign stop_det  = pins_s.scl & scl_q & ~sda_q & pins_s.sda;

  // ****************************************************************
  // Decoding helpers
  // ****************************************************************
  // Maps a subaddress to a channel number, zero when out of range.
  function automatic logic [1:0] sub_channel(input logic [7:0] sub);
    logic [1:0] ch;
    ch = 2'h0;
    case (sub)
      `VBIC_SUB_CH1: ch = 2'h1;
      `VBIC_SUB_CH2: ch = 2'h2;
      `VBIC_SUB_CH3: ch = 2'h3;
      default:       ch = 2'h0;
    endcase
    return ch;
  endfunction

  vbic_state_t state_q;
  logic [3:0]  bit_cnt_q;
  logic [7:0]  shift_q;
  logic [7:0]  tx_q;
  logic [7:0]  sub_q;
  logic        rw_q;
  logic        stuck_q;
  logic        scl_seen_q;
  logic        byte_full;
  logic        addr_match;
  logic        drive_low;
  logic [7:0]  read_byte;

  assign byte_full = (bit_cnt_q == `VBIC_BYTE_BITS);

  // Select pins are compared as they stand now, so moving a pin moves the address.
  assign addr_match = (shift_q[7:3] == `VBIC_ADDR_FIXED) &&
                      (shift_q[`VBIC_ADDR_SEL_HI_BIT] == pins_s.sel_high) &&
                      (shift_q[`VBIC_ADDR_SEL_LO_BIT] == pins_s.sel_low);

  // ****************************************************************
  // Receive shifter and bit counter
  // ****************************************************************
  // Bits are taken on the rising clock while the line is stable.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bit_cnt_q <= 4'h0;
      shift_q   <= 8'h00;
    end else if (start_det || stop_det) begin
      bit_cnt_q <= 4'h0;
    end else if (scl_rise && (state_q == VBIC_ST_ADDR || state_q == VBIC_ST_SUB ||
                              state_q == VBIC_ST_DATA || state_q == VBIC_ST_RD_DATA)) begin
      shift_q   <= {shift_q[6:0], pins_s.sda};
      bit_cnt_q <= bit_cnt_q + 4'h1;
    end else if (scl_fall && byte_full) begin
      bit_cnt_q <= 4'h0;
    end
  end

  // ****************************************************************
  // Transaction sequencer
  // ****************************************************************
  // State moves on the falling clock so the line changes only while the clock is low.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= VBIC_ST_IDLE;
      rw_q    <= 1'b0;
    end else if (start_det) begin
      state_q <= VBIC_ST_ADDR;
    end else if (stop_det) begin
      state_q <= VBIC_ST_IDLE;
    end else if (scl_fall) begin
      case (state_q)
        VBIC_ST_ADDR: begin
          if (byte_full) begin
            state_q <= addr_match ? VBIC_ST_ADDR_ACK : VBIC_ST_IGNORE;
            rw_q    <= shift_q[`VBIC_ADDR_RW_BIT];
          end
        end
        VBIC_ST_ADDR_ACK: begin
          state_q <= rw_q ? VBIC_ST_RD_DATA : VBIC_ST_SUB;
        end
        VBIC_ST_SUB: begin
          if (byte_full) begin
            state_q <= VBIC_ST_SUB_ACK;
          end
        end
        VBIC_ST_SUB_ACK: begin
          state_q <= VBIC_ST_DATA;
        end
        VBIC_ST_DATA: begin
          if (byte_full) begin
            state_q <= VBIC_ST_DATA_ACK;
          end
        end
        VBIC_ST_DATA_ACK: begin
          state_q <= VBIC_ST_IGNORE;
        end
        VBIC_ST_RD_DATA: begin
          if (byte_full) begin
            state_q <= VBIC_ST_RD_ACK;
          end
        end
        VBIC_ST_RD_ACK: begin
          state_q <= VBIC_ST_IGNORE;
        end
        default: begin
          state_q <= state_q;
        end
      endcase
    end
  end

  // The selected subaddress persists so a later read returns that channel.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sub_q <= 8'h00;
    end else if (scl_fall && state_q == VBIC_ST_SUB && byte_full) begin
      sub_q <= shift_q;
    end
  end

  // ****************************************************************
  // Channel registers and decoded outputs
  // ****************************************************************
  // Reset loads the part-specific power-up pattern, not a clean value.
  for (genvar i = 0; i < NUM_CH; i++) begin : g_chan
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        chan_cfg_q[i] <= vbic_chan_cfg_t'(POWERUP_CFG[8*i +: 8]);
      end else if (scl_fall && state_q == VBIC_ST_DATA && byte_full &&
                   sub_channel(sub_q) == 2'(i + 1)) begin
        chan_cfg_q[i] <= vbic_chan_cfg_t'(shift_q);
      end
    end

    // Clamp corner matters only while a tip clamp bias is chosen.
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        sync_tip_clamp_q[i] <= 1'b0;
        clamp_corner_q[i]   <= VBIC_CLAMP_LOW;
      end else begin
        sync_tip_clamp_q[i] <= chan_cfg_q[i][`VBIC_BIAS_HI_BIT] & (|chan_cfg_q[i].bias_mode[1:0]);
        if (chan_cfg_q[i][`VBIC_CLAMP_HI_BIT]) begin
          clamp_corner_q[i] <= VBIC_CLAMP_HIGH;
        end else if (chan_cfg_q[i][`VBIC_CLAMP_LO_BIT]) begin
          clamp_corner_q[i] <= VBIC_CLAMP_MID;
        end else begin
          clamp_corner_q[i] <= VBIC_CLAMP_LOW;
        end
      end
    end
  end

  // Out-of-range subaddresses read back as a fixed filler byte.
  always_comb begin
    case (sub_channel(sub_q))
      2'h1:    read_byte = chan_cfg_q[0];
      2'h2:    read_byte = chan_cfg_q[1];
      2'h3:    read_byte = chan_cfg_q[2];
      default: read_byte = `VBIC_READ_INVALID;
    endcase
  end

  // Transmit byte is loaded as the address acknowledge ends, then shifted per clock.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_q <= 8'h00;
    end else if (scl_fall && state_q == VBIC_ST_ADDR_ACK && rw_q) begin
      tx_q <= read_byte;
    end else if (scl_fall && state_q == VBIC_ST_RD_DATA) begin
      tx_q <= {tx_q[6:0], 1'b0};
    end
  end

  // ****************************************************************
  // Stuck acknowledge and data line drive
  // ****************************************************************
  // A full clock means a rise and then a fall; a lone fall would release too early.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stuck_q    <= STUCK_AT_POWERUP;
      scl_seen_q <= 1'b0;
    end else if (stuck_q) begin
      if (scl_rise) begin
        scl_seen_q <= 1'b1;
      end
      if (scl_fall && scl_seen_q) begin
        stuck_q <= 1'b0;
      end
    end
  end

  assign drive_low = stuck_q ||
                     state_q == VBIC_ST_ADDR_ACK ||
                     state_q == VBIC_ST_SUB_ACK ||
                     state_q == VBIC_ST_DATA_ACK ||
                     (state_q == VBIC_ST_RD_DATA && !tx_q[7]);

  // Open-drain: the output level is always low, only the enable moves.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sda_out_q  <= 1'b0;
      sda_oe_n_q <= 1'b1;
    end else begin
      sda_out_q  <= 1'b0;
      sda_oe_n_q <= ~drive_low;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_stuck_release;
    (stuck_q && scl_seen_q && scl_fall) |=> !stuck_q ##1 (sda_oe_n_q == ~drive_low);
  endproperty
  a_stuck_release: assert property (p_stuck_release) else $error("stuck ack not released");

  property p_addr_ack;
    (scl_fall && state_q == VBIC_ST_ADDR && byte_full && addr_match && !start_det && !stop_det)
      |=> (state_q == VBIC_ST_ADDR_ACK) ##1 !sda_oe_n_q;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("matching address not acknowledged");

  property p_ack_high;
    (state_q == VBIC_ST_ADDR_ACK && pins_s.scl && scl_q) |-> !sda_oe_n_q;
  endproperty
  a_ack_high: assert property (p_ack_high) else $error("data released during ack high");

  property p_nomatch;
    (scl_fall && state_q == VBIC_ST_ADDR && byte_full && !addr_match && !stuck_q && !start_det && !stop_det)
      |=> (state_q == VBIC_ST_IGNORE) ##1 sda_oe_n_q;
  endproperty
  a_nomatch: assert property (p_nomatch) else $error("unmatched address driven");

  property p_write_ch1;
    (scl_fall && state_q == VBIC_ST_DATA && byte_full && sub_q == `VBIC_SUB_CH1 && !start_det && !stop_det)
      |=> (chan_cfg_q[0] == $past(shift_q)) && $stable(chan_cfg_q[1]) && $stable(chan_cfg_q[2]);
  endproperty
  a_write_ch1: assert property (p_write_ch1) else $error("channel one write wrong");

  property p_bad_sub;
    (state_q == VBIC_ST_DATA && sub_channel(sub_q) == 2'h0)
      |=> $stable(chan_cfg_q[0]) && $stable(chan_cfg_q[1]) && $stable(chan_cfg_q[2]);
  endproperty
  a_bad_sub: assert property (p_bad_sub) else $error("bad subaddress changed a channel");

  property p_read_load;
    (scl_fall && state_q == VBIC_ST_ADDR_ACK && rw_q && !start_det && !stop_det)
      |=> (state_q == VBIC_ST_RD_DATA) && (tx_q == $past(read_byte)) ##1 (sda_oe_n_q == tx_q[7]);
  endproperty
  a_read_load: assert property (p_read_load) else $error("read byte not presented");

  property p_stop_idle;
    stop_det |=> (state_q == VBIC_ST_IDLE) && (bit_cnt_q == 4'h0);
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stop did not abort");

  property p_single_byte;
    (scl_fall && state_q == VBIC_ST_DATA_ACK && !start_det && !stop_det)
      |=> (state_q == VBIC_ST_IGNORE) ##1 (sda_oe_n_q == ~stuck_q);
  endproperty
  a_single_byte: assert property (p_single_byte) else $error("second data byte accepted");

  property p_clamp_decode;
    (chan_cfg_q[0].clamp_filter == 2'b11 && chan_cfg_q[0].bias_mode == VBIC_BIAS_TIP_HIGH)
      |=> (clamp_corner_q[0] == VBIC_CLAMP_HIGH) && sync_tip_clamp_q[0];
  endproperty
  a_clamp_decode: assert property (p_clamp_decode) else $error("clamp decode wrong");

  c_write: cover property (scl_fall && state_q == VBIC_ST_DATA_ACK);
  c_read:  cover property (scl_fall && state_q == VBIC_ST_RD_ACK);
  c_miss:  cover property (scl_fall && state_q == VBIC_ST_ADDR && byte_full && !addr_match);
  c_stuck: cover property ($fell(stuck_q));

endmodule

// ==== testbench/vbic_master.sv ====
// ****************************************************************
// Two-wire bus master model
// ****************************************************************
module vbic_master (
  // Clock
  input  wire logic clk,
  // Bus lines
  input  wire logic sda_wire,
  output logic      scl_pin,
  output logic      sda_low
);
  timeunit 1ns;
  timeprecision 1ps;

  // Quarter bit in system clocks; raising it models a slow master.
  int gap = 4;

  // The bus idles with both lines released to the pull-ups.
  initial begin
    scl_pin = 1'b1;
    sda_low = 1'b0;
  end

  // Every line change lands just after a rising edge of the system clock.
  task automatic wt();
    repeat (gap) @(posedge clk);
  endtask

  // Start or repeated start; data is released first so no stop is seen.
  task automatic start();
    wt();
    sda_low <= 1'b0;
    wt();
    scl_pin <= 1'b1;
    wt();
    sda_low <= 1'b1;
    wt();
    scl_pin <= 1'b0;
  endtask

  // Stop: data rises while the clock is high.
  task automatic stop();
    wt();
    sda_low <= 1'b1;
    wt();
    scl_pin <= 1'b1;
    wt();
    sda_low <= 1'b0;
    wt();
  endtask

  // A lone falling clock edge.
  task automatic fall();
    wt();
    scl_pin <= 1'b0;
  endtask

  // One bit: data set while the clock is low, sampled in mid high phase.
  task automatic bit_cyc(input logic b, output logic s);
    wt();
    sda_low <= ~b;
    wt();
    scl_pin <= 1'b1;
    wt();
    s = sda_wire;
    wt();
    scl_pin <= 1'b0;
  endtask

  // Byte MSB first, then the ninth clock with data released for the ack.
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cyc(b[i], s);
    end
    bit_cyc(1'b1, ack);
  endtask

  // One byte from the slave, answered with a not-acknowledge.
  task automatic rbyte(output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cyc(1'b1, d[i]);
    end
    bit_cyc(1'b1, s);
  endtask

  // Leading bits of a byte only, used to cut a byte short.
  task automatic bits(input logic [7:0] b, input int n);
    logic s;
    for (int i = 0; i < n; i++) begin
      bit_cyc(b[7 - i], s);
    end
  endtask

  // Power-up flush: a zero byte and its ninth clock, ack ignored, then stop.
  task automatic flush();
    logic s;
    for (int i = 0; i < 9; i++) begin
      bit_cyc(1'b0, s);
    end
    stop();
  endtask
endmodule

// ==== testbench/tb_vbic_slave.sv ====
`include "vbic_defines.svh"

`define CHK(nm, ex, got) \
  begin \
    total_checks++; \
    if ((got) !== (ex)) begin \
      err_count++; \
      $display("[ERR] %s expected %h seen %h", nm, ex, got); \
    end \
  end

module tb_vbic_slave import vbic_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Signals and reference state
  // ****************************************************************
  logic           clk          = 1'b0;
  logic           sys_rst      = 1'b1;
  logic           sel_hi       = 1'b0;
  logic           sel_lo       = 1'b0;
  logic           scl_pin;
  logic           sda_low;
  logic           sda_out_q;
  logic           sda_oe_n_q;
  logic           sda_wire;
  vbic_chan_cfg_t chan_cfg_q [3];
  logic [2:0]     sync_tip_clamp_q;
  vbic_clamp_t    clamp_corner_q [3];
  int             err_count    = 0;
  int             total_checks = 0;
  logic [7:0]     mcfg [3];
  logic [7:0]     msub         = 8'h00;
  logic [31:0]    rs           = 32'h5FED;

  // 200 MHz system clock.
  always #2.5 clk = ~clk;

  // Open-drain data line with pull-up: low if either party pulls.
  assign sda_wire = sda_low ? 1'b0 : (sda_oe_n_q ? 1'b1 : sda_out_q);

  vbic_slave i_vbic_slave (
    .clk                  (clk),
    .sys_rst              (sys_rst),
    .scl_pin              (scl_pin),
    .sda_in               (sda_wire),
    .sda_out_q            (sda_out_q),
    .sda_oe_n_q           (sda_oe_n_q),
    .addr_select_high_pin (sel_hi),
    .addr_select_low_pin  (sel_lo),
    .chan_cfg_q           (chan_cfg_q),
    .sync_tip_clamp_q     (sync_tip_clamp_q),
    .clamp_corner_q       (clamp_corner_q)
  );

  vbic_master i_vbic_master (
    .clk      (clk),
    .sda_wire (sda_wire),
    .scl_pin  (scl_pin),
    .sda_low  (sda_low)
  );

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  // Address byte from the select pins as they stand now.
  function automatic logic [7:0] adr(input logic rw);
    return {`VBIC_ADDR_FIXED, sel_hi, sel_lo, rw};
  endfunction

  // All channels against the reference, raw byte and decoded outputs.
  task automatic chk_regs();
    for (int c = 0; c < 3; c++) begin
      `CHK("cfg", mcfg[c], chan_cfg_q[c])
      `CHK("tip", mcfg[c][2:0] >= 3'h5, sync_tip_clamp_q[c])
      `CHK("clamp", mcfg[c][7] ? 2'h2 : mcfg[c][7:6], clamp_corner_q[c])
    end
  endtask

  // Write transfer: address, then n bytes out of subaddress, data, extra.
  task automatic wr(input logic [7:0] a, input logic [7:0] s, input logic [7:0] d, input int n);
    logic       hit;
    logic       ak;
    logic [7:0] b [3];
    hit = (a[7:3] == `VBIC_ADDR_FIXED) && (a[2:1] == {sel_hi, sel_lo}) && !a[0];
    b = '{s, d, ~d};
    i_vbic_master.start();
    i_vbic_master.wbyte(a, ak);
    `CHK("addr_ack", !hit, ak)
    for (int k = 0; k < n; k++) begin
      i_vbic_master.wbyte(b[k], ak);
      `CHK("byte_ack", !(hit && k < 2), ak)
    end
    i_vbic_master.stop();
    if (hit) begin
      msub = s;
      if (n > 1 && s >= 8'h01 && s <= 8'h03) begin
        mcfg[s - 8'h01] = d;
      end
    end
    chk_regs();
  endtask

  // Read transfer of one byte from the selected channel.
  task automatic rd();
    logic       ak;
    logic [7:0] d;
    i_vbic_master.start();
    i_vbic_master.wbyte(adr(1'b1), ak);
    `CHK("rd_ack", 1'b0, ak)
    i_vbic_master.rbyte(d);
    i_vbic_master.stop();
    `CHK("rd_data", (msub >= 8'h01 && msub <= 8'h03) ? mcfg[msub - 8'h01] : `VBIC_READ_INVALID, d)
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    logic s;
    {mcfg[2], mcfg[1], mcfg[0]} = `VBIC_POWERUP_CFG;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK("stuck", 1'b0, sda_wire)
    i_vbic_master.fall();
    repeat (10) @(posedge clk);
    `CHK("stuck_fall", 1'b0, sda_wire)
    i_vbic_master.bit_cyc(1'b1, s);
    repeat (10) @(posedge clk);
    `CHK("stuck_free", 1'b1, sda_oe_n_q)
    i_vbic_master.flush();
    chk_regs();
    // Channels in turn with every bias and clamp code; pins move between writes.
    for (int i = 0; i < 16; i++) begin
      rs = xs(rs);
      sel_hi <= rs[8];
      sel_lo <= rs[9];
      repeat (4) @(posedge clk);
      wr(adr(1'b0), 8'(i % 3 + 1), {i[3:2], rs[2:0], i[2:0]}, 2);
    end
    // Read-back through a slow master.
    i_vbic_master.gap = 12;
    for (int c = 1; c <= 3; c++) begin
      wr(adr(1'b0), 8'(c), 8'h00, 1);
      rd();
    end
    i_vbic_master.gap = 4;
    // Foreign addresses, out-of-range channel, extra byte.
    wr({`VBIC_ADDR_FIXED, ~sel_hi, sel_lo, 1'b0}, 8'h01, 8'hAA, 2);
    wr({`VBIC_ADDR_FIXED ^ 5'h10, sel_hi, sel_lo, 1'b0}, 8'h02, 8'h55, 2);
    wr(adr(1'b0), 8'h04, 8'h3C, 2);
    rd();
    wr(adr(1'b0), 8'h02, 8'hC6, 3);
    rd();
    // Byte cut short by a repeated start, then by a stop.
    i_vbic_master.start();
    i_vbic_master.bits(adr(1'b0), 4);
    wr(adr(1'b0), 8'h03, rs[7:0], 2);
    i_vbic_master.start();
    i_vbic_master.bits(adr(1'b0), 5);
    i_vbic_master.stop();
    rd();
    close_out();
  end

  // A hang counts as a mismatch.
  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    close_out();
  end
endmodule
